// ===== src/dic_pkg.sv
// dic_pkg: constants for the interrupt status, mask and input-change block
// assumes a 32-bit AHB-Lite slave wrapper; byte-wide registers in the low bits
package dic_pkg;

  // ************************************************************
  // register map (word indexes from haddr[9:2]; byte offsets are four times these)
  // ************************************************************
  localparam logic [7:0] DIC_IDX_CHANGE = 8'h04;
  localparam logic [7:0] DIC_IDX_STATUS = 8'h05;
  localparam logic [7:0] DIC_IDX_AUX = 8'h06;
  localparam logic [7:0] DIC_IDX_CMD = 8'h07;
  localparam logic [7:0] DIC_IDX_RAWSTAT = 8'h08;
  localparam int DIC_ADDR_LSB = 2;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int DIC_BIT_IN_CHG = 7;
  localparam int DIC_BIT_BRK_B = 6;
  localparam int DIC_BIT_RX_B = 5;
  localparam int DIC_BIT_TX_B = 4;
  localparam int DIC_BIT_CTR = 3;
  localparam int DIC_BIT_BRK_A = 2;
  localparam int DIC_BIT_RX_A = 1;
  localparam int DIC_BIT_TX_A = 0;
  localparam logic [7:0] DIC_STATUS_RST = 8'h00;
  localparam logic [7:0] DIC_MASK_RST = 8'h00;
  localparam logic [3:0] DIC_AUX_RST = 4'h0;
  // command register write codes
  localparam logic [1:0] DIC_CMD_BRK_A = 2'h1;
  localparam logic [1:0] DIC_CMD_BRK_B = 2'h2;
  localparam logic [1:0] DIC_CMD_STOP = 2'h3;

endpackage : dic_pkg

// ===== src/dic_top.sv
// dic_top: interrupt status, mask and input-change logic with an AHB-Lite slave
// assumes pins and event strobes synchronous to hclk; event strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module dic_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic gen_input_0,
  input wire logic gen_input_1,
  input wire logic gen_input_2,
  input wire logic gen_input_3,
  input wire logic brk_chg_a,
  input wire logic brk_chg_b,
  input wire logic chan_a_rx_irq,
  input wire logic chan_b_rx_irq,
  input wire logic chan_a_tx_irq,
  input wire logic chan_b_tx_irq,
  input wire logic ctr_zero,
  input wire logic ctr_timer_mode,
  output logic irq_out_n,
  output logic [7:0] status_out
);

  // ************************************************************
  // bus address phase capture
  // ************************************************************
  logic rd_pend;
  logic wr_pend;
  logic [7:0] idx_pend;
  logic [7:0] idx_now;
  logic take;
  assign idx_now = haddr[9:2];
  assign take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      idx_pend <= 8'h00;
    end else begin
      rd_pend <= take & ~hwrite;
      wr_pend <= take & hwrite;
      idx_pend <= take ? idx_now : idx_pend;
    end
  end

  // reads are selected in the address phase and registered for the data phase; zero wait states
  wire rd_chg_now = take & ~hwrite & (idx_now == dic_pkg::DIC_IDX_CHANGE);
  wire wr_mask = wr_pend & (idx_pend == dic_pkg::DIC_IDX_STATUS);
  wire wr_aux = wr_pend & (idx_pend == dic_pkg::DIC_IDX_AUX);
  wire wr_cmd = wr_pend & (idx_pend == dic_pkg::DIC_IDX_CMD);
  wire [1:0] cmd = hwdata[1:0];
  wire clr_brk_a = wr_cmd & (cmd == dic_pkg::DIC_CMD_BRK_A);
  wire clr_brk_b = wr_cmd & (cmd == dic_pkg::DIC_CMD_BRK_B);
  wire stop_ctr = wr_cmd & (cmd == dic_pkg::DIC_CMD_STOP);

  // ************************************************************
  // input change detection
  // ************************************************************
  logic [3:0] pins;
  logic [3:0] pins_q;
  logic [3:0] chg;
  logic [7:0] mask;
  logic [3:0] aux;
  logic [7:0] status;
  logic timer_half;
  assign pins = {gen_input_3, gen_input_2, gen_input_1, gen_input_0};
  wire [3:0] edge_det = pins ^ pins_q;
  // change snapshot read happens at address phase so the clear and set do not race
  wire [3:0] next_chg = edge_det | (rd_chg_now ? 4'h0 : chg);
  wire in_chg_set = |(edge_det & aux);
  wire ctr_set = ctr_zero & (~ctr_timer_mode | timer_half);

  // the new mask takes effect on the interrupt output in the same edge it is loaded
  wire [7:0] next_mask = wr_mask ? hwdata[7:0] : mask;

  logic [7:0] next_status;
  always_comb begin
    next_status = status;
    if (rd_chg_now) next_status[dic_pkg::DIC_BIT_IN_CHG] = 1'b0;
    if (clr_brk_a) next_status[dic_pkg::DIC_BIT_BRK_A] = 1'b0;
    if (clr_brk_b) next_status[dic_pkg::DIC_BIT_BRK_B] = 1'b0;
    if (stop_ctr) next_status[dic_pkg::DIC_BIT_CTR] = 1'b0;
    // sets win over clears
    if (in_chg_set) next_status[dic_pkg::DIC_BIT_IN_CHG] = 1'b1;
    if (brk_chg_b) next_status[dic_pkg::DIC_BIT_BRK_B] = 1'b1;
    if (brk_chg_a) next_status[dic_pkg::DIC_BIT_BRK_A] = 1'b1;
    if (ctr_set) next_status[dic_pkg::DIC_BIT_CTR] = 1'b1;
    next_status[dic_pkg::DIC_BIT_RX_B] = chan_b_rx_irq;
    next_status[dic_pkg::DIC_BIT_RX_A] = chan_a_rx_irq;
    next_status[dic_pkg::DIC_BIT_TX_B] = chan_b_tx_irq;
    next_status[dic_pkg::DIC_BIT_TX_A] = chan_a_tx_irq;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_q <= 4'h0;
      chg <= 4'h0;
      status <= dic_pkg::DIC_STATUS_RST;
      mask <= dic_pkg::DIC_MASK_RST;
      aux <= dic_pkg::DIC_AUX_RST;
      timer_half <= 1'b0;
    end else begin
      pins_q <= pins;
      chg <= next_chg;
      status <= next_status;
      mask <= next_mask;
      aux <= wr_aux ? hwdata[3:0] : aux;
      // stop does not halt the timer, so the phase keeps toggling
      timer_half <= ctr_zero ? ~timer_half : timer_half;
    end
  end

  // ************************************************************
  // read data, outputs
  // ************************************************************
  logic [7:0] chg_snap;
  logic [7:0] rd_byte;
  wire [7:0] rd_sel =
    (idx_now == dic_pkg::DIC_IDX_CHANGE) ? {chg | edge_det, pins} :
    (idx_now == dic_pkg::DIC_IDX_STATUS) ? status :
    (idx_now == dic_pkg::DIC_IDX_AUX) ? {4'h0, aux} :
    (idx_now == dic_pkg::DIC_IDX_RAWSTAT) ? mask : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_byte <= 8'h00;
      irq_out_n <= 1'b1;
      status_out <= 8'h00;
    end else begin
      rd_byte <= (take & ~hwrite) ? rd_sel : 8'h00;
      irq_out_n <= ~|(next_status & next_mask);
      status_out <= next_status;
    end
  end
  assign chg_snap = rd_byte;
  assign hrdata = {24'h000000, chg_snap};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : dic_top
`default_nettype wire

// ===== dv/dic_evt_src.sv
// dic_evt_src: far-side pins and event strobes for the interrupt block
// assumes the bench changes req just after hclk rises
`timescale 1ns/1ps
`default_nettype none
module dic_evt_src (
  input wire logic hclk,
  input wire logic [6:0] req,
  output logic [6:0] drv
);
  // one register stage, as a synchronised pin would arrive
  always_ff @(posedge hclk) begin
    drv <= req;
  end
endmodule : dic_evt_src
`default_nettype wire

// ===== dv/dic_checker.sv
// dic_checker: bus and status properties of dic_top
// assumes zero-wait reads and events synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
module dic_checker (
  input wire logic hclk, hresetn, hsel, hwrite, brk_chg_a, brk_chg_b, chan_a_rx_irq, chan_a_tx_irq, irq_out_n,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hrdata,
  input wire logic [7:0] status_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd = hsel && htrans[1] && !hwrite;
  wire logic wr = hsel && htrans[1] && hwrite;
  sequence rd_at(logic [7:0] i); rd && haddr[9:2] == i; endsequence
  AST_IRQ: assert property (status_out == 8'h00 |-> irq_out_n) else $error("irq low, no status");
  AST_TXA: assert property (chan_a_tx_irq |=> status_out[0]) else $error("tx a not shown");
  AST_RXA: assert property ($fell(chan_a_rx_irq) |=> !status_out[1]) else $error("rx a stuck");
  AST_BRKA: assert property (brk_chg_a |=> status_out[2]) else $error("break a not set");
  AST_BRKB: assert property (brk_chg_b |=> status_out[6]) else $error("break b not set");
  // break flag A may only drop two cycles after a bus write
  AST_BCLR: assert property ($fell(status_out[2]) |-> $past(wr, 2)) else $error("break a lost");
  AST_ST: assert property (rd_at(8'h05) |=> hrdata == {24'h0, $past(status_out)}) else $error("status read");
  AST_GAP: assert property (rd_at(8'h10) |=> hrdata == 32'h0) else $error("unmapped read");
endmodule : dic_checker
bind dic_top dic_checker u_chk (.hclk, .hresetn, .hsel, .hwrite, .brk_chg_a, .brk_chg_b, .chan_a_rx_irq,
  .chan_a_tx_irq, .irq_out_n, .htrans, .haddr, .hrdata, .status_out);
`default_nettype wire

// ===== dv/tb.sv
// tb: register tests of dic_top over AHB-Lite
// assumes a zero-wait slave; pins and strobes come through dic_evt_src
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic hclk, hresetn, hsel, hwrite, ctr_timer_mode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] lv;
  logic [6:0] req;
  logic [7:0] s;
  logic [31:0] haddr, hwdata, q;
  wire logic hready, irq_out_n, gen_input_0, gen_input_1, gen_input_2, gen_input_3, brk_chg_a, brk_chg_b, ctr_zero;
  wire logic [31:0] hrdata;
  int mismatches = 0, checked = 0, cyc = 0;
  dic_evt_src src (.hclk, .req, .drv({ctr_zero, brk_chg_b, brk_chg_a, gen_input_3, gen_input_2, gen_input_1, gen_input_0}));
  dic_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp(), .gen_input_0, .gen_input_1, .gen_input_2, .gen_input_3, .brk_chg_a, .brk_chg_b,
    .chan_a_rx_irq(lv[1]), .chan_b_rx_irq(lv[3]), .chan_a_tx_irq(lv[0]), .chan_b_tx_irq(lv[2]), .ctr_zero,
    .ctr_timer_mode, .irq_out_n, .status_out());
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // called just after a rising edge; each phase is held until hready is seen high at a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    do @(posedge hclk); while (hready !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    // read data is taken at the edge that ends the data phase
    q = hrdata;
  endtask : bus
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, {24'h0, e});
  endtask : rc
  // strobes in r[6:4] last one cycle, pin levels in r[3:0] stay
  task automatic ev(input logic [6:0] r);
    req <= r;
    @(posedge hclk);
    req <= {3'h0, r[3:0]};
    repeat (3) @(posedge hclk);
  endtask : ev
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, ctr_timer_mode, htrans, lv, req, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(32'h14, 8'h00);
    ev(7'h0a);
    rc(32'h10, 8'haa);
    rc(32'h10, 8'h0a);
    rc(32'h40, 8'h00);
    $display("test 1 done");
    bus(1'b1, 32'h18, 32'h1);
    bus(1'b1, 32'h14, 32'h80);
    rc(32'h20, 8'h80);
    ev(7'h0b);
    chk({31'h0, irq_out_n}, 32'h0);
    rc(32'h14, 8'h80);
    rc(32'h10, 8'h1b);
    rc(32'h14, 8'h00);
    ev(7'h09);
    rc(32'h14, 8'h00);
    lv <= 4'hf;
    repeat (2) @(posedge hclk);
    rc(32'h14, 8'h33);
    chk({31'h0, irq_out_n}, 32'h1);
    lv <= 4'h0;
    $display("test 2 done");
    ev(7'h19);
    ev(7'h29);
    rc(32'h14, 8'h44);
    bus(1'b1, 32'h1c, 32'h1);
    rc(32'h14, 8'h40);
    bus(1'b1, 32'h1c, 32'h2);
    rc(32'h14, 8'h00);
    ev(7'h49);
    rc(32'h14, 8'h08);
    bus(1'b1, 32'h1c, 32'h3);
    rc(32'h14, 8'h00);
    ctr_timer_mode <= 1'b1;
    ev(7'h49);
    bus(1'b0, 32'h14, 32'h0);
    s = q[7:0];
    bus(1'b1, 32'h1c, 32'h3);
    ev(7'h49);
    bus(1'b0, 32'h14, 32'h0);
    chk({24'h0, s ^ q[7:0]}, 32'h08);
    $display("test 3 done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
